//--- dv/mtf_back_end_model.sv
// Back-end partner model answering dispatched requests
`timescale 1ns/10ps
module mtf_back_end_model
    import mtf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic fail_mode,
    input wire logic [7:0] exc_code,
    output logic req_done,
    output logic req_fail,
    output logic [7:0] req_exc_code,
    output logic [15:0] resp_pdu_len
);
    logic [3:0] wait_reg;
    logic busy_reg;
    logic [7:0] seq_reg;
    // Delay threshold steps by 3 per request and wraps at 8, so prompt and slow replies both occur
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 4'h0;
            busy_reg <= 1'b0;
            req_done <= 1'b0;
            seq_reg <= 8'h00;
        end else begin
            req_done <= 1'b0;
            if (!req_valid) begin
                busy_reg <= 1'b0;
                wait_reg <= 4'h0;
            end else if (!busy_reg) begin
                wait_reg <= wait_reg + 4'h1;
                if (wait_reg >= {1'b0, seq_reg[2:0]}) begin
                    req_done <= 1'b1;
                    busy_reg <= 1'b1; // Request stays up a cycle after done
                    seq_reg <= seq_reg + 8'h03;
                end
            end
        end
    end
    // Result lines hold no old value outside the done pulse
    assign req_fail = req_done ? fail_mode : ~fail_mode;
    assign req_exc_code = req_done ? exc_code : ~exc_code;
    assign resp_pdu_len = req_done ? 16'h0006 : 16'hfff9; // No checksum bytes
endmodule // mtf_back_end_model

//--- dv/mtf_front_end_checker.sv
// Checker: port-level properties of the request front end
`timescale 1ns/10ps
module mtf_front_end_checker
    import mtf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic conn_open,
    input wire logic [15:0] conn_port,
    input wire logic req_valid,
    input wire logic [7:0] req_fc,
    input wire logic [2:0] req_op,
    input wire logic req_little_end,
    input wire logic req_done,
    input wire logic req_fail,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    input wire logic tx_hdr_end,
    input wire logic tx_ready,
    input wire logic conn_accept,
    input wire logic frame_dropped
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_port; 1'b1 |=> conn_accept == $past(conn_open && conn_port == MTF_SERVER_PORT);
    endproperty
    a_port: assert property (p_port) else $error("accept differs from port check");
    property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(tx_last);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx byte moved while stalled");
    property p_req_hold; req_valid && !req_done |=> req_valid && $stable(req_fc); endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");
    property p_le; req_valid |-> req_little_end == (req_fc inside {8'h2b, 8'h65, 8'h66});
    endproperty
    a_le: assert property (p_le) else $error("byte order flag wrong");
    property p_encap; req_valid && req_fc == MTF_FC_ENCAP |-> req_op == MTF_OP_ENCAP; endproperty
    a_encap: assert property (p_encap) else $error("encap op wrong");
    property p_dict; req_valid && req_fc inside {8'h65, 8'h66} |-> req_op inside {3'h2, 3'h3};
    endproperty
    a_dict: assert property (p_dict) else $error("dictionary op wrong");
    property p_reg; req_valid && !req_little_end |-> req_op == MTF_OP_REG; endproperty
    a_reg: assert property (p_reg) else $error("register op wrong");
    property p_answer; req_done && req_valid && !req_fail |-> ##2 tx_valid; endproperty
    a_answer: assert property (p_answer) else $error("no answer two cycles after done");
    property p_drop; frame_dropped |=> (!frame_dropped && !req_valid && !tx_valid)[*3];
    endproperty
    a_drop: assert property (p_drop) else $error("dropped frame got a reaction");
    property p_hdr_end; tx_hdr_end |-> tx_last && tx_valid; endproperty
    a_hdr_end: assert property (p_hdr_end) else $error("header end outside last byte");
endmodule // mtf_front_end_checker

bind mtf_front_end mtf_front_end_checker u_chk (.ref_clk, .rst_n, .conn_open, .conn_port,
    .req_valid, .req_fc, .req_op, .req_little_end, .req_done, .req_fail, .tx_valid, .tx_byte,
    .tx_last, .tx_hdr_end, .tx_ready, .conn_accept, .frame_dropped);

//--- dv/mtf_front_end_tb_top.sv
// Testbench of the request front end
`timescale 1ns/10ps
module mtf_front_end_tb_top;
    import mtf_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic conn_open = 1'b0;
    logic [15:0] conn_port = MTF_SERVER_PORT;
    logic rx_valid = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic rx_last = 1'b0;
    logic tx_ready = 1'b0;
    logic fail_mode = 1'b0;
    logic [7:0] exc_code = 8'h04;
    logic req_valid, req_little_end, req_done, req_fail, tx_valid, tx_last, tx_hdr_end;
    logic conn_accept, frame_dropped;
    logic [7:0] req_fc, req_len, req_exc_code, tx_byte;
    logic [2:0] req_op;
    logic [15:0] resp_pdu_len;
    logic [7:0] fr[$];
    logic [7:0] txq[$];
    logic [15:0] tid = 16'h1230;
    logic [7:0] rd_addr, rd_data;
    // Event counters have one writer; tasks keep a base and compare the step
    int req_cycles = 0;
    int drop_pulses = 0;
    int hdr_ends = 0;
    int req_base, drop_base, hdr_base;
    int errors = 0;
    int comparisons = 0;
    initial forever #2 ref_clk = ~ref_clk;
    mtf_front_end uut (.ref_clk, .rst_n, .conn_open, .conn_port, .rx_valid, .rx_byte, .rx_last,
        .req_valid, .req_fc, .req_op, .req_little_end, .req_len, .req_rd_addr(rd_addr),
        .req_rd_data(rd_data),
        .req_done, .req_fail, .req_exc_code, .resp_pdu_len, .tx_valid, .tx_byte, .tx_last,
        .tx_hdr_end, .tx_ready, .conn_accept, .frame_dropped);
    mtf_back_end_model u_be (.ref_clk, .rst_n, .req_valid, .fail_mode, .exc_code, .req_done,
        .req_fail, .req_exc_code, .resp_pdu_len);
    // Stall every other cycle and collect what leaves
    always @(posedge ref_clk) begin
        tx_ready <= ~tx_ready;
        if (tx_valid && tx_ready) txq.push_back(tx_byte);
        if (req_valid) req_cycles <= req_cycles + 1;
        if (frame_dropped) drop_pulses <= drop_pulses + 1;
        if (tx_valid && tx_ready && tx_hdr_end) hdr_ends <= hdr_ends + 1;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic build(input logic [15:0] pid, input logic [15:0] len, input logic [7:0] unit,
            input logic [7:0] fc, input logic [7:0] sub);
        tid = tid + 16'h0001; // Client bumps the id per query
        fr = {tid[15:8], tid[7:0], pid[15:8], pid[7:0], len[15:8], len[7:0], unit, fc, sub,
            8'h13, 8'h88, 8'h02};
        txq.delete();
        req_base = req_cycles;
        drop_base = drop_pulses;
        hdr_base = hdr_ends;
    endtask
    task automatic send();
        foreach (fr[i]) begin
            @(posedge ref_clk);
            rx_valid <= 1'b1;
            rx_byte <= fr[i];
            rx_last <= (i == fr.size() - 1);
        end
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
    endtask
    // Full request and answer; unsupported codes expect exception 01
    task automatic txn(input logic [7:0] fc, input logic [7:0] sub, input logic [2:0] op,
            input logic le, input logic sup, input logic fail);
        logic [7:0] exp[$];
        fail_mode <= fail;
        build(MTF_PROTO_ID, 16'h0006, MTF_UNIT_ID, fc, sub);
        send();
        if (sup) begin
            for (int i = 0; i < 40 && req_valid !== 1'b1; i++) @(posedge ref_clk);
            chk(req_valid, 1'b1);
            chk(req_fc, fc);
            chk(req_op, op);
            chk(req_little_end, le);
            chk(req_len, 8'h05);
            if (req_valid !== 1'b1) end_of_test();
            // Read port lags its index by one cycle: index 1 is the subfunction
            @(posedge ref_clk);
            chk(rd_addr, 8'h02);
            chk(rd_data, sub);
            @(posedge ref_clk);
            chk(rd_data, 8'h13);
        end
        if (sup && !fail) exp = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, fc};
        else exp = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, fc | MTF_EXC_FLAG,
            sup ? exc_code : MTF_EXC_ILLEGAL_FC};
        for (int i = 0; i < 80 && txq.size() < exp.size(); i++) @(posedge ref_clk);
        chk(16'(txq.size()), 16'(exp.size()));
        foreach (exp[i]) chk(txq[i], exp[i]);
        if (txq.size() < exp.size()) end_of_test();
        repeat (4) @(posedge ref_clk);
        // Header end marks the fc byte of normal answers only
        chk(16'(hdr_ends - hdr_base), {15'h0000, sup && !fail});
    endtask
    task automatic drop(input logic [15:0] pid, input logic [15:0] len, input logic [7:0] unit);
        build(pid, len, unit, MTF_FC_RD_HOLD, 8'h00);
        send();
        repeat (10) @(posedge ref_clk);
        chk(16'(drop_pulses - drop_base), 16'h0001);
        chk(16'(req_cycles - req_base), 16'h0000);
        chk(16'(txq.size()), 16'h0000);
    endtask
    task automatic wrong_port();
        conn_port <= 16'h01f7;
        build(MTF_PROTO_ID, 16'h0006, MTF_UNIT_ID, MTF_FC_RD_HOLD, 8'h00);
        send();
        repeat (10) @(posedge ref_clk);
        chk(conn_accept, 1'b0);
        chk(16'(req_cycles - req_base), 16'h0000);
        chk(16'(txq.size()), 16'h0000);
        conn_port <= MTF_SERVER_PORT;
        repeat (3) @(posedge ref_clk);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] reg_fc[5];
        reg_fc = '{8'h03, 8'h04, 8'h06, 8'h10, 8'h17};
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        conn_open <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk(conn_accept, 1'b1);
        foreach (reg_fc[i]) txn(reg_fc[i], 8'h00, MTF_OP_REG, 1'b0, 1'b1, 1'b0);
        txn(MTF_FC_ENCAP, MTF_SUB_ENCAP, MTF_OP_ENCAP, 1'b1, 1'b1, 1'b0);
        txn(MTF_FC_DICT, MTF_SUB_START, MTF_OP_START, 1'b1, 1'b1, 1'b0);
        txn(MTF_FC_DICT, MTF_SUB_NEXT, MTF_OP_NEXT, 1'b1, 1'b1, 1'b0);
        txn(MTF_FC_RECORD, MTF_SUB_START, MTF_OP_START, 1'b1, 1'b1, 1'b0);
        txn(MTF_FC_RECORD, MTF_SUB_NEXT, MTF_OP_NEXT, 1'b1, 1'b1, 1'b0);
        txn(8'h07, 8'h00, MTF_OP_REG, 1'b0, 1'b0, 1'b0);
        txn(MTF_FC_ENCAP, 8'h0e, MTF_OP_REG, 1'b0, 1'b0, 1'b0);
        for (int c = 1; c < 5; c++) begin
            exc_code <= 8'(c);
            txn(MTF_FC_WR_SINGLE, 8'h00, MTF_OP_REG, 1'b0, 1'b1, 1'b1);
        end
        drop(16'h0001, 16'h0006, MTF_UNIT_ID);
        drop(MTF_PROTO_ID, 16'h0007, MTF_UNIT_ID);
        drop(MTF_PROTO_ID, 16'h0001, MTF_UNIT_ID);
        drop(MTF_PROTO_ID, 16'h0006, 8'h01);
        wrong_port();
        txn(MTF_FC_RD_HOLD, 8'h00, MTF_OP_REG, 1'b0, 1'b1, 1'b0);
        end_of_test();
    end
endmodule // mtf_front_end_tb_top

//--- rtl/mtf_fc_decode.sv
// Function code classifier of the request front end
`timescale 1ns/10ps
module mtf_fc_decode
    import mtf_pkg::*;
(
    input wire logic [7:0] fc,
    input wire logic [7:0] sub,
    output logic supported,
    output logic little_end,
    output logic [2:0] op
);
    // ------------------------------------------------------------------
    // Classification
    // ------------------------------------------------------------------
    // Pure combinational; the parent registers its results
    always_comb begin
        supported = 1'b0;
        little_end = 1'b0;
        op = MTF_OP_REG;
        case (fc)
            MTF_FC_RD_HOLD, MTF_FC_RD_INPUT, MTF_FC_WR_SINGLE,
            MTF_FC_WR_MULTI, MTF_FC_RD_WR: begin
                supported = 1'b1;
            end
            MTF_FC_ENCAP: begin
                supported = (sub == MTF_SUB_ENCAP);
                little_end = 1'b1;
                op = MTF_OP_ENCAP;
            end
            MTF_FC_DICT, MTF_FC_RECORD: begin
                little_end = 1'b1;
                if (sub == MTF_SUB_START) begin
                    supported = 1'b1;
                    op = MTF_OP_START;
                end else if (sub == MTF_SUB_NEXT) begin
                    supported = 1'b1;
                    op = MTF_OP_NEXT;
                end
            end
            default: begin
                supported = 1'b0;
            end
        endcase
    end
endmodule // mtf_fc_decode

//--- rtl/mtf_front_end.sv
// Request front end: header check, dispatch and response header build
`timescale 1ns/10ps
module mtf_front_end
    import mtf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    // Stream from the TCP stack
    input wire logic conn_open,
    input wire logic [15:0] conn_port,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_last,
    // Back end request
    output logic req_valid,
    output logic [7:0] req_fc,
    output logic [2:0] req_op,
    output logic req_little_end,
    output logic [7:0] req_len,
    output logic [7:0] req_rd_addr,
    output logic [7:0] req_rd_data,
    input wire logic req_done,
    input wire logic req_fail,
    input wire logic [7:0] req_exc_code,
    input wire logic [15:0] resp_pdu_len,
    // Response header stream toward the stack
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic tx_last,
    output logic tx_hdr_end,
    input wire logic tx_ready,
    output logic conn_accept,
    output logic frame_dropped
);
    typedef enum {S_HDR, S_BODY, S_DISCARD, S_DISPATCH, S_WAIT, S_TX} mtf_state_e;
    mtf_state_e state_reg;
    logic [2:0] hdr_cnt_reg;
    logic [15:0] tid_reg, pid_reg, len_reg;
    logic [7:0] unit_reg;
    logic [15:0] body_cnt_reg;
    logic [7:0] sub_reg;
    logic [7:0] pdu_mem [MTF_BUF_DEPTH];
    logic [7:0] tx_fc_reg, tx_exc_reg;
    logic tx_is_exc_reg;
    logic [15:0] tx_len_reg;
    logic [3:0] tx_idx_reg;
    logic dec_sup, dec_le;
    logic [2:0] dec_op;
    logic port_ok;
    logic [15:0] body_next;

    mtf_fc_decode u_dec (
        .fc(pdu_mem[0]),
        .sub(sub_reg),
        .supported(dec_sup),
        .little_end(dec_le),
        .op(dec_op)
    );

    // ------------------------------------------------------------------
    // Connection gate
    // ------------------------------------------------------------------
    assign port_ok = conn_open && (conn_port == MTF_SERVER_PORT);
    assign body_next = body_cnt_reg + 16'h0001;

    // Only one session: the stack presents a single connection; flag it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            conn_accept <= 1'b0;
        end else begin
            conn_accept <= port_ok;
        end
    end

    // ------------------------------------------------------------------
    // Receive: header capture, body store, checks
    // ------------------------------------------------------------------
    // No checksum bytes are expected after the body
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_HDR;
            hdr_cnt_reg <= 3'h0;
            tid_reg <= 16'h0000;
            pid_reg <= 16'h0000;
            len_reg <= 16'h0000;
            unit_reg <= 8'h00;
            body_cnt_reg <= 16'h0000;
            sub_reg <= 8'h00;
            frame_dropped <= 1'b0;
            req_valid <= 1'b0;
            req_fc <= 8'h00;
            req_op <= MTF_OP_REG;
            req_little_end <= 1'b0;
            req_len <= 8'h00;
            tx_fc_reg <= 8'h00;
            tx_exc_reg <= 8'h00;
            tx_is_exc_reg <= 1'b0;
            tx_len_reg <= 16'h0000;
        end else begin
            frame_dropped <= 1'b0;
            case (state_reg)
                S_HDR: begin
                    if (rx_valid && port_ok) begin
                        // Big-endian header fields
                        case (hdr_cnt_reg)
                            3'h0: tid_reg[15:8] <= rx_byte;
                            3'h1: tid_reg[7:0] <= rx_byte;
                            3'h2: pid_reg[15:8] <= rx_byte;
                            3'h3: pid_reg[7:0] <= rx_byte;
                            3'h4: len_reg[15:8] <= rx_byte;
                            3'h5: len_reg[7:0] <= rx_byte;
                            default: unit_reg <= rx_byte;
                        endcase
                        body_cnt_reg <= 16'h0000;
                        if (rx_last) begin
                            hdr_cnt_reg <= 3'h0;
                            frame_dropped <= 1'b1;
                        end else if (hdr_cnt_reg == 3'(MTF_HDR_BYTES - 4'h1)) begin
                            hdr_cnt_reg <= 3'h0;
                            // Length must also fit the body store
                            if (pid_reg != MTF_PROTO_ID || len_reg < MTF_LEN_MIN ||
                                len_reg > MTF_LEN_MAX) begin
                                state_reg <= S_DISCARD;
                            end else begin
                                state_reg <= S_BODY;
                            end
                        end else begin
                            hdr_cnt_reg <= hdr_cnt_reg + 3'h1;
                        end
                    end
                end
                S_BODY: begin
                    if (rx_valid) begin
                        body_cnt_reg <= body_next;
                        if (body_cnt_reg == 16'h0001) begin
                            sub_reg <= rx_byte;
                        end
                        if (rx_last) begin
                            // Length counts unit id plus fc and data
                            if (body_next + 16'h0001 != len_reg) begin
                                frame_dropped <= 1'b1;
                                state_reg <= S_HDR;
                            end else if (unit_reg != MTF_UNIT_ID) begin
                                frame_dropped <= 1'b1;
                                state_reg <= S_HDR;
                            end else begin
                                state_reg <= S_DISPATCH;
                            end
                        end
                    end
                end
                S_DISCARD: begin
                    if (rx_valid && rx_last) begin
                        frame_dropped <= 1'b1;
                        state_reg <= S_HDR;
                    end
                end
                S_DISPATCH: begin
                    tx_fc_reg <= pdu_mem[0];
                    if (!dec_sup) begin
                        tx_is_exc_reg <= 1'b1;
                        tx_exc_reg <= MTF_EXC_ILLEGAL_FC;
                        tx_len_reg <= MTF_EXC_LEN;
                        state_reg <= S_TX;
                    end else begin
                        req_valid <= 1'b1;
                        req_fc <= pdu_mem[0];
                        req_op <= dec_op;
                        req_little_end <= dec_le;
                        req_len <= body_cnt_reg[7:0];
                        state_reg <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (req_done) begin
                        req_valid <= 1'b0;
                        tx_is_exc_reg <= req_fail;
                        tx_exc_reg <= req_exc_code;
                        // Length: unit id plus the back end's PDU
                        tx_len_reg <= req_fail ? MTF_EXC_LEN : resp_pdu_len + 16'h0001;
                        state_reg <= S_TX;
                    end
                end
                S_TX: begin
                    if (tx_ready && tx_valid && tx_last) begin
                        tx_is_exc_reg <= 1'b0;
                        state_reg <= S_HDR;
                    end
                end
                default: state_reg <= S_HDR;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Body store; the back end reads payload bytes by index
    // ------------------------------------------------------------------
    // Memory left without reset to keep it a plain RAM
    always_ff @(posedge ref_clk) begin
        if (state_reg == S_BODY && rx_valid) begin
            pdu_mem[body_cnt_reg[7:0]] <= rx_byte;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_rd_data <= 8'h00;
        end else begin
            req_rd_data <= pdu_mem[req_rd_addr];
        end
    end

    // ------------------------------------------------------------------
    // Transmit: response header, then fc (and exception code)
    // ------------------------------------------------------------------
    // Normal answers: header plus fc byte, back end streams the rest
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid <= 1'b0;
            tx_byte <= 8'h00;
            tx_last <= 1'b0;
            tx_hdr_end <= 1'b0;
            tx_idx_reg <= 4'h0;
        end else if (state_reg != S_TX) begin
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
            tx_hdr_end <= 1'b0;
            tx_idx_reg <= 4'h0;
        end else if (!tx_valid || tx_ready) begin
            if (tx_valid && tx_last) begin
                tx_valid <= 1'b0;
                tx_last <= 1'b0;
                tx_hdr_end <= 1'b0;
            end else begin
                tx_valid <= 1'b1;
                tx_idx_reg <= tx_idx_reg + 4'h1;
                tx_hdr_end <= 1'b0;
                tx_last <= 1'b0;
                case (tx_idx_reg)
                    4'h0: tx_byte <= tid_reg[15:8];
                    4'h1: tx_byte <= tid_reg[7:0];
                    4'h2: tx_byte <= MTF_PROTO_ID[15:8];
                    4'h3: tx_byte <= MTF_PROTO_ID[7:0];
                    4'h4: tx_byte <= tx_len_reg[15:8];
                    4'h5: tx_byte <= tx_len_reg[7:0];
                    4'h6: tx_byte <= MTF_UNIT_ID;
                    4'h7: begin
                        // Error code is fc with top bit set
                        tx_byte <= tx_is_exc_reg ? (tx_fc_reg | MTF_EXC_FLAG) : tx_fc_reg;
                        tx_hdr_end <= !tx_is_exc_reg;
                        tx_last <= !tx_is_exc_reg;
                    end
                    default: begin
                        tx_byte <= tx_exc_reg;
                        tx_last <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Back end index is driven from its own counter; expose as flop
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_rd_addr <= 8'h00;
        end else if (state_reg == S_DISPATCH) begin
            req_rd_addr <= 8'h01;
        end else if (state_reg == S_WAIT && req_rd_addr < req_len) begin
            req_rd_addr <= req_rd_addr + 8'h01;
        end
    end
endmodule // mtf_front_end

//--- rtl/mtf_pkg.sv
// Package: constants of the request front end
package mtf_pkg;
    // ------------------------------------------------------------------
    // Connection and header
    // ------------------------------------------------------------------
    localparam logic [15:0] MTF_SERVER_PORT = 16'h01f6;
    localparam logic [3:0] MTF_HDR_BYTES = 4'h7;
    localparam logic [15:0] MTF_PROTO_ID = 16'h0000;
    localparam logic [7:0] MTF_UNIT_ID = 8'h00;
    localparam logic [15:0] MTF_LEN_MIN = 16'h0002;
    localparam logic [15:0] MTF_LEN_MAX = 16'h00fe;
    localparam int MTF_BUF_DEPTH = 256;
    // ------------------------------------------------------------------
    // Function, subfunction and exception codes
    // ------------------------------------------------------------------
    localparam logic [7:0] MTF_FC_RD_HOLD = 8'h03;
    localparam logic [7:0] MTF_FC_RD_INPUT = 8'h04;
    localparam logic [7:0] MTF_FC_WR_SINGLE = 8'h06;
    localparam logic [7:0] MTF_FC_WR_MULTI = 8'h10;
    localparam logic [7:0] MTF_FC_RD_WR = 8'h17;
    localparam logic [7:0] MTF_FC_ENCAP = 8'h2b;
    localparam logic [7:0] MTF_FC_DICT = 8'h65;
    localparam logic [7:0] MTF_FC_RECORD = 8'h66;
    localparam logic [7:0] MTF_SUB_ENCAP = 8'h0d;
    localparam logic [7:0] MTF_SUB_START = 8'h55;
    localparam logic [7:0] MTF_SUB_NEXT = 8'haa;
    localparam logic [7:0] MTF_EXC_FLAG = 8'h80;
    localparam logic [7:0] MTF_EXC_ILLEGAL_FC = 8'h01;
    localparam logic [15:0] MTF_EXC_LEN = 16'h0003;
    // ------------------------------------------------------------------
    // Dispatch kinds seen by the back end
    // ------------------------------------------------------------------
    localparam logic [2:0] MTF_OP_REG = 3'h0;
    localparam logic [2:0] MTF_OP_ENCAP = 3'h1;
    localparam logic [2:0] MTF_OP_START = 3'h2;
    localparam logic [2:0] MTF_OP_NEXT = 3'h3;
endpackage
